// ---- hdl/rtms_pkg.sv ----
// Constants, types and helper functions for the radio transmit mode sequencer
package rtms_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS = 8'h04;
    localparam logic [7:0] REG_CONFIG_OFS = 8'h08;

    // Control register fields and reset values
    localparam int         CTRL_WAKE_BIT   = 0;
    localparam logic       CTRL_WAKE_RESET = 1'b0;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_CFGD_BIT  = 9;
    localparam int STAT_RFON_BIT  = 10;
    localparam int STAT_CNT_LSB   = 16;

    // Configuration word layout and value after reset
    localparam int          CFG_WIDTH     = 20;
    localparam logic [19:0] CFG_RESET     = 20'h30F02;
    localparam int          CFG_BURST_BIT = 13;
    localparam int          CFG_RATE_BIT  = 12;
    localparam int          CFG_XO_LSB    = 9;
    localparam int          CFG_PWR_LSB   = 7;
    localparam int          CFG_CH_LSB    = 0;

    // Timing, in the printed units
    localparam int SLEEP_TO_ACTIVE_TIME_MS = 3;
    localparam int IDLE_TO_BURST_TX_TIME_NS = 195000;
    localparam int DIRECT_FIXED_A_NS        = 194000;
    localparam int DIRECT_FIXED_B_NS        = 2250;
    localparam int DIRECT_XO_PERIODS        = 20;
    localparam int BIT_TIME_FAST_NS         = 1000;
    localparam int BIT_TIME_SLOW_NS         = 4000;

    // Derived cycle counts; longest times round down
    localparam int SLEEP_TO_ACTIVE_CYC = SLEEP_TO_ACTIVE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Cycles from a pin edge to the state machine acting on it
    localparam int SYNC_LAG_CYC        = 3;
    localparam int IDLE_TO_BURST_CYC   = IDLE_TO_BURST_TX_TIME_NS / CLK_PERIOD_NS;
    localparam int DIRECT_FIXED_CYC    = (DIRECT_FIXED_A_NS + DIRECT_FIXED_B_NS)
                                         / CLK_PERIOD_NS;
    localparam logic [18:0] BIT_FAST_CYC = 19'(BIT_TIME_FAST_NS / CLK_PERIOD_NS);
    localparam logic [18:0] BIT_SLOW_CYC = 19'(BIT_TIME_SLOW_NS / CLK_PERIOD_NS);

    // Burst payload store
    localparam int PAYLOAD_BITS = 256;

    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        LOW_POWER_STATE  = 9'h001,
        WAKE_STATE       = 9'h002,
        IDLE_WAIT_STATE  = 9'h004,
        CONFIG_STATE     = 9'h008,
        BURST_LOAD_STATE = 9'h010,
        BURST_WAIT_STATE = 9'h020,
        BURST_AIR_STATE  = 9'h040,
        DIRECT_WAIT_STATE = 9'h080,
        DIRECT_AIR_STATE = 9'h100
    } rtms_state_t;

    // Cycles taken by twenty oscillator periods for a crystal code
    function automatic logic [18:0] xo_term_cyc(input logic [2:0] code);
        int mhz;
        mhz = (code > 3'h4) ? 20 : 4 * (int'(code) + 1);
        return 19'(DIRECT_XO_PERIODS * 1000 / mhz / CLK_PERIOD_NS);
    endfunction : xo_term_cyc

    // Output power in dBm for the two-bit power field
    function automatic logic [7:0] power_dbm(input logic [1:0] code);
        unique case (code)
            2'h3:    power_dbm = 8'h00;
            2'h2:    power_dbm = 8'hFB;
            2'h1:    power_dbm = 8'hF6;
            default: power_dbm = 8'hEC;
        endcase
    endfunction : power_dbm

endpackage : rtms_pkg

// ---- hdl/rtms_cfg_load.sv ----
// Configuration shift register with partial load on select release
`timescale 1ns/1ns
`default_nettype none
module rtms_cfg_load (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Serial side
    input  wire logic        shift_i,
    input  wire logic        bit_i,
    input  wire logic        apply_i,
    // Configuration out
    output logic [19:0]      cfg_o,
    output logic             loaded_o
);

    logic [19:0] shift_reg;
    logic [19:0] shift_next;
    logic [4:0]  count_reg;
    logic [4:0]  count_next;
    logic [19:0] cfg_reg;
    logic [19:0] cfg_next;
    logic [19:0] mask;
    logic        loaded_reg;

    // Each bit enters at the bottom so the first bit ends highest
    assign shift_next = {shift_reg[18:0], bit_i};
    // Count saturates; extra bits only push out the oldest ones
    assign count_next = (count_reg == 5'h14) ? count_reg : count_reg + 5'h01;
    // Only the bits shifted this time replace the low end of the word
    assign mask     = 20'((21'h000001 << count_reg) - 21'h000001);
    assign cfg_next = (cfg_reg & ~mask) | (shift_reg & mask);

    // Shift while selected, apply on the select release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg  <= 20'h00000;
            count_reg  <= 5'h00;
            cfg_reg    <= rtms_pkg::CFG_RESET;
            loaded_reg <= 1'b0;
        end else if (apply_i) begin
            cfg_reg    <= cfg_next;
            count_reg  <= 5'h00;
            loaded_reg <= 1'b1;
        end else if (shift_i) begin
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    assign cfg_o    = cfg_reg;
    assign loaded_o = loaded_reg;

endmodule : rtms_cfg_load
`default_nettype wire

// ---- hdl/rtms_seq.sv ----
// Mode and timing sequencer for the radio transmitter control pins
`timescale 1ns/1ns
`default_nettype none
module rtms_seq #(
    parameter int SLEEP_CYC  = rtms_pkg::SLEEP_TO_ACTIVE_CYC,
    parameter int BURST_CYC  = rtms_pkg::IDLE_TO_BURST_CYC,
    parameter int DIRECT_CYC = rtms_pkg::DIRECT_FIXED_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Control pins from the host
    input  wire logic        cs_i,
    input  wire logic        ce_i,
    input  wire logic        sclk_i,
    input  wire logic        din_i,
    // Radio side
    output logic             rf_on_o,
    output logic             tx_data_o,
    output logic [6:0]       channel_o,
    output logic [7:0]       power_dbm_o,
    output logic             fast_rate_o
);

    rtms_pkg::rtms_state_t state_reg;
    rtms_pkg::rtms_state_t state_next;

    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  pin_s3;
    logic        cs_s;
    logic        ce_s;
    logic        sclk_s;
    logic        din_s;
    logic        sclk_rise;
    logic        cs_fall;

    logic [19:0] cfg;
    logic        configured;
    logic        burst_mode;
    logic [18:0] bit_cyc;

    logic [18:0] timer_reg;
    logic [18:0] timer_next;
    logic        timer_zero;
    logic        timer_load;

    logic        pay_mem [rtms_pkg::PAYLOAD_BITS];
    logic [8:0]  pay_cnt_reg;
    logic [8:0]  pay_idx_reg;
    logic        capture;
    logic        air_tick;

    logic        wake_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        bus_req;
    logic        wr_ctrl;
    logic        tx_data_reg;
    logic        tx_data_next;

    // Two-flop synchronisers for the host pins, third stage for edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
        end else begin
            pin_s1 <= {din_i, sclk_i, ce_i, cs_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Synchronised levels and edges
    assign cs_s      = pin_s2[0];
    assign ce_s      = pin_s2[1];
    assign sclk_s    = pin_s2[2];
    assign din_s     = pin_s2[3];
    assign sclk_rise = sclk_s & ~pin_s3[2];
    assign cs_fall   = ~cs_s & pin_s3[0];

    // Configuration register shifts only inside configuration mode
    rtms_cfg_load u_cfg (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .shift_i  (sclk_rise && state_reg == rtms_pkg::CONFIG_STATE),
        .bit_i    (din_s),
        .apply_i  (cs_fall && state_reg == rtms_pkg::CONFIG_STATE),
        .cfg_o    (cfg),
        .loaded_o (configured)
    );

    // Decoded configuration fields
    assign burst_mode  = cfg[rtms_pkg::CFG_BURST_BIT];
    assign bit_cyc     = cfg[rtms_pkg::CFG_RATE_BIT] ? rtms_pkg::BIT_FAST_CYC
                                                     : rtms_pkg::BIT_SLOW_CYC;
    assign channel_o   = cfg[rtms_pkg::CFG_CH_LSB +: 7];
    assign power_dbm_o = rtms_pkg::power_dbm(cfg[rtms_pkg::CFG_PWR_LSB +: 2]);
    assign fast_rate_o = cfg[rtms_pkg::CFG_RATE_BIT];

    // Shared timer events
    assign timer_zero = (timer_reg == 19'h00000);
    assign air_tick   = (state_reg == rtms_pkg::BURST_AIR_STATE) && timer_zero;
    assign capture    = (state_reg == rtms_pkg::BURST_LOAD_STATE) && sclk_rise;

    // Next state; in idle, select wins if the host raises both pins
    always_comb begin
        state_next = state_reg;
        timer_load = 1'b0;
        timer_next = 19'h00000;
        unique case (state_reg)
            rtms_pkg::LOW_POWER_STATE: begin
                if (wake_reg) begin
                    state_next = rtms_pkg::WAKE_STATE;
                    timer_load = 1'b1;
                    timer_next = 19'(SLEEP_CYC - 1);
                end
            end
            rtms_pkg::WAKE_STATE: begin
                if (timer_zero) begin
                    state_next = rtms_pkg::IDLE_WAIT_STATE;
                end
            end
            rtms_pkg::IDLE_WAIT_STATE: begin
                if (!wake_reg) begin
                    state_next = rtms_pkg::LOW_POWER_STATE;
                end else if (cs_s) begin
                    state_next = rtms_pkg::CONFIG_STATE;
                end else if (ce_s && configured) begin
                    if (burst_mode) begin
                        state_next = rtms_pkg::BURST_LOAD_STATE;
                    end else begin
                        state_next = rtms_pkg::DIRECT_WAIT_STATE;
                        timer_load = 1'b1;
                        // Fixed part plus twenty crystal periods
                        timer_next = 19'(DIRECT_CYC - 1)
                                   + rtms_pkg::xo_term_cyc(cfg[rtms_pkg::CFG_XO_LSB +: 3]);
                    end
                end
            end
            rtms_pkg::CONFIG_STATE: begin
                if (!cs_s) begin
                    state_next = rtms_pkg::IDLE_WAIT_STATE;
                end
            end
            rtms_pkg::BURST_LOAD_STATE: begin
                if (!ce_s) begin
                    state_next = rtms_pkg::BURST_WAIT_STATE;
                    timer_load = 1'b1;
                    // Sync lag is part of the budget, so air starts on time
                    timer_next = 19'(BURST_CYC - rtms_pkg::SYNC_LAG_CYC - 1);
                end
            end
            rtms_pkg::BURST_WAIT_STATE: begin
                if (timer_zero) begin
                    state_next = rtms_pkg::BURST_AIR_STATE;
                    timer_load = 1'b1;
                    timer_next = bit_cyc - 19'h00001;
                end
            end
            rtms_pkg::BURST_AIR_STATE: begin
                if (timer_zero) begin
                    // Last period is the trailing one after the payload
                    if (pay_idx_reg == pay_cnt_reg) begin
                        state_next = rtms_pkg::IDLE_WAIT_STATE;
                    end else begin
                        timer_load = 1'b1;
                        timer_next = bit_cyc - 19'h00001;
                    end
                end
            end
            rtms_pkg::DIRECT_WAIT_STATE: begin
                if (!ce_s) begin
                    state_next = rtms_pkg::IDLE_WAIT_STATE;
                end else if (timer_zero) begin
                    state_next = rtms_pkg::DIRECT_AIR_STATE;
                end
            end
            rtms_pkg::DIRECT_AIR_STATE: begin
                // Airtime is bounded by the host; no cutoff here
                if (!ce_s) begin
                    state_next = rtms_pkg::IDLE_WAIT_STATE;
                end
            end
            default: begin
                state_next = rtms_pkg::LOW_POWER_STATE;
            end
        endcase
    end

    // State and timer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= rtms_pkg::LOW_POWER_STATE;
            timer_reg <= 19'h00000;
        end else begin
            state_reg <= state_next;
            if (timer_load) begin
                timer_reg <= timer_next;
            end else if (!timer_zero) begin
                timer_reg <= timer_reg - 19'h00001;
            end
        end
    end

    // Payload bit count; restarts each time a burst load begins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pay_cnt_reg <= 9'h000;
        end else if (state_reg == rtms_pkg::IDLE_WAIT_STATE) begin
            pay_cnt_reg <= 9'h000;
        end else if (capture && pay_cnt_reg != 9'h100) begin
            pay_cnt_reg <= pay_cnt_reg + 9'h001;
        end
    end

    // Payload store; bits beyond its size are dropped
    always_ff @(posedge clk_i) begin
        if (capture && pay_cnt_reg != 9'h100) begin
            pay_mem[pay_cnt_reg[7:0]] <= din_s;
        end
    end

    // Bit index walks the payload once per bit period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pay_idx_reg <= 9'h000;
        end else if (state_reg != rtms_pkg::BURST_AIR_STATE) begin
            pay_idx_reg <= 9'h000;
        end else if (air_tick) begin
            pay_idx_reg <= pay_idx_reg + 9'h001;
        end
    end

    // Modulator data: stored bits in burst, pin level in direct
    always_comb begin
        tx_data_next = 1'b0;
        if (state_reg == rtms_pkg::BURST_AIR_STATE && pay_idx_reg < pay_cnt_reg) begin
            tx_data_next = pay_mem[pay_idx_reg[7:0]];
        end else if (state_reg == rtms_pkg::DIRECT_AIR_STATE) begin
            tx_data_next = din_s;
        end
    end

    // Registered modulator data output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_reg <= 1'b0;
        end else begin
            tx_data_reg <= tx_data_next;
        end
    end

    assign tx_data_o = tx_data_reg;
    assign rf_on_o   = (state_reg == rtms_pkg::BURST_AIR_STATE)
                     | (state_reg == rtms_pkg::DIRECT_AIR_STATE);

    // Bus decode; ack goes low a cycle after each answer
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == rtms_pkg::REG_CTRL_OFS);

    // Read mux; unmapped offsets read zero but still answer
    always_comb begin
        rdata_next = 32'h00000000;
        unique case (wb_adr_i)
            rtms_pkg::REG_CTRL_OFS: begin
                rdata_next[rtms_pkg::CTRL_WAKE_BIT] = wake_reg;
            end
            rtms_pkg::REG_STATUS_OFS: begin
                rdata_next[rtms_pkg::STAT_STATE_LSB +: 9] = state_reg;
                rdata_next[rtms_pkg::STAT_CFGD_BIT]       = configured;
                rdata_next[rtms_pkg::STAT_RFON_BIT]       = rf_on_o;
                rdata_next[rtms_pkg::STAT_CNT_LSB +: 9]   = pay_cnt_reg;
            end
            rtms_pkg::REG_CONFIG_OFS: begin
                rdata_next[19:0] = cfg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // Bus registers; wake steers leaving and entering low power
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_reg  <= rtms_pkg::CTRL_WAKE_RESET;
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                rdata_reg <= rdata_next;
            end
            if (wr_ctrl) begin
                wake_reg <= wb_dat_i[rtms_pkg::CTRL_WAKE_BIT];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

endmodule : rtms_seq
`default_nettype wire

// ---- dv/rtms_seq_properties.sv ----
// Port checks for the radio transmit mode sequencer
`timescale 1ns/1ns
`default_nettype none
module rtms_seq_properties #(
    parameter int BURST_CYC  = 40,
    parameter int DIRECT_CYC = 40
) (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Bus
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // Pins
    input wire logic       cs_i,
    input wire logic       ce_i,
    input wire logic       din_i,
    // Radio side
    input wire logic       rf_on_o,
    input wire logic       tx_data_o,
    input wire logic [6:0] channel_o,
    input wire logic [7:0] power_dbm_o,
    input wire logic       fast_rate_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    // Enable run lengths; saturate so long idles never wrap
    always_ff @(posedge clk_i) begin
        hi_cnt <= (rst_i || !ce_i) ? 16'h0 : hi_cnt + {15'h0, ~&hi_cnt};
        lo_cnt <= (rst_i || ce_i) ? 16'h0 : lo_cnt + {15'h0, ~&lo_cnt};
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_air_up;
        $rose(rf_on_o);
    endsequence
    property p_ack_next;
        s_req |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_cfg_apply;
        $changed({channel_o, power_dbm_o, fast_rate_o}) |-> !cs_i && ($past(cs_i, 2)
            || $past(cs_i, 3) || $past(cs_i, 4) || $past(cs_i, 5) || $past(cs_i, 6));
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("config moved without select fall");
    property p_power;
        power_dbm_o inside {8'h00, 8'hFB, 8'hF6, 8'hEC};
    endproperty
    a_power: assert property (p_power) else $error("power level not a legal code");
    property p_burst_dly;
        s_air_up ##0 !ce_i |-> lo_cnt >= BURST_CYC && lo_cnt <= BURST_CYC + 8;
    endproperty
    a_burst_dly: assert property (p_burst_dly) else $error("burst air start off");
    property p_direct_dly;
        s_air_up ##0 ce_i |-> hi_cnt >= DIRECT_CYC + 100 && hi_cnt <= DIRECT_CYC + 508;
    endproperty
    a_direct_dly: assert property (p_direct_dly) else $error("direct air start off");
    property p_direct_smp;
        rf_on_o && ce_i && $past(rf_on_o, 6) |-> tx_data_o == $past(din_i, 3)
            || tx_data_o == $past(din_i, 4) || tx_data_o == $past(din_i, 5);
    endproperty
    a_direct_smp: assert property (p_direct_smp) else $error("direct data not followed");
    property p_no_air_cfg;
        s_air_up |-> !cs_i;
    endproperty
    a_no_air_cfg: assert property (p_no_air_cfg) else $error("air began under select");
endmodule : rtms_seq_properties
bind rtms_seq rtms_seq_properties #(.BURST_CYC(BURST_CYC), .DIRECT_CYC(DIRECT_CYC)) chk_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cs_i, .ce_i,
    .din_i, .rf_on_o, .tx_data_o, .channel_o, .power_dbm_o, .fast_rate_o);
`default_nettype wire

// ---- dv/rtms_host_model.sv ----
// Host controller model driving the select, enable, clock and data pins
`timescale 1ns/1ns
`default_nettype none
module rtms_host_model (
    // Clock
    input  wire logic clk_i,
    // Control pins
    output var logic  cs_o,
    output var logic  ce_o,
    output var logic  sclk_o,
    output var logic  din_o
);
    // Pins quiet at time zero; serial clock stands still between frames
    initial begin
        cs_o = 1'b0;
        ce_o = 1'b0;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    // Clocked frame under select or enable, 80 ns serial clock
    task automatic frame(input logic use_cs, input int n, input logic [31:0] w, input int tail);
        @(posedge clk_i);
        cs_o <= use_cs; // Only one of the two ever high
        ce_o <= !use_cs;
        repeat (500) @(posedge clk_i); // Settle before first bit
        for (int i = n - 1; i >= 0; i--) begin // MSB first, 1 to 32 bits
            din_o <= w[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (tail + 4) @(posedge clk_i); // Hold, plus synchroniser lag for the last clock edge
        cs_o <= 1'b0;
        ce_o <= 1'b0;
        din_o <= ~din_o; // Released line must not look stable
    endtask : frame
    // Clockless packet; sclk held low, rate exact
    task automatic direct(input int n, input logic [31:0] w, input int bit_cyc);
        @(posedge clk_i);
        ce_o <= 1'b1;
        repeat (500) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            din_o <= w[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        ce_o <= 1'b0;
        din_o <= ~din_o;
    endtask : direct
endmodule : rtms_host_model
`default_nettype wire

// ---- dv/test_radio_tx_mode_sequencer.sv ----
// Self-checking bench for the radio transmit mode sequencer
`timescale 1ns/1ns
`default_nettype none
module test_radio_tx_mode_sequencer;
    localparam int DIR = 40;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, cs_i, ce_i, sclk_i, din_i, rf_on_o, tx_data_o, fast_rate_o;
    logic [6:0]  channel_o;
    logic [7:0]  power_dbm_o;
    logic [15:0] dly = 16'h0;
    logic [15:0] dly_on = 16'h0;
    logic [15:0] on_cnt = 16'h0;
    logic        rf_q = 1'b0;
    logic [19:0] cfg;
    logic [31:0] q, w;
    int          n_errors = 0;
    int          checks_done = 0;
    int          seed = 65879;
    int          n, code;
    always #5 clk_i = ~clk_i;
    rtms_seq #(.SLEEP_CYC(50), .BURST_CYC(40), .DIRECT_CYC(DIR)) dut_u (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .cs_i, .ce_i, .sclk_i, .din_i, .rf_on_o, .tx_data_o, .channel_o,
        .power_dbm_o, .fast_rate_o);
    rtms_host_model host_u (.clk_i, .cs_o(cs_i), .ce_o(ce_i), .sclk_o(sclk_i), .din_o(din_i));
    // Enable-to-air delay and airtime, both held for reading later
    always @(posedge clk_i) begin
        rf_q <= rf_on_o;
        dly <= ce_i ? dly + 16'h1 : 16'h0;
        if (rf_on_o && !rf_q) dly_on <= dly;
        if (rf_on_o) on_cnt <= rf_q ? on_cnt + 16'h1 : 16'h1;
    end
    function automatic logic [7:0] dbm(input logic [1:0] c);
        return (c == 2'h3) ? 8'h00 : (c == 2'h2) ? 8'hFB : (c == 2'h1) ? 8'hF6 : 8'hEC;
    endfunction : dbm
    // Twenty oscillator periods in 10 ns cycles
    function automatic int xo_cyc(input int c);
        return 2000 / ((c > 4) ? 20 : 4 * (c + 1));
    endfunction : xo_cyc
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Classic single cycle; a lost ack ends the run
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i >= 20) begin
            check("wb ack", 32'h0, 32'h1);
            results();
        end
    endtask : wb
    task automatic wait_air(input logic lvl);
        int i;
        for (i = 0; i < 3000 && rf_on_o !== lvl; i++) @(posedge clk_i);
        if (i >= 3000) begin
            check("rf_on wait", {31'h0, ~lvl}, {31'h0, lvl});
            results();
        end
    endtask : wait_air
    // Load a config frame and compare the register image
    task automatic load(input int bits);
        host_u.frame(1'b1, bits, w, 0);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < bits; i++) cfg[i] = w[i];
        wb(1'b0, 8'h08, 32'h0);
        check("config word", q, {12'h0, cfg});
        check("channel", {25'h0, channel_o}, {25'h0, cfg[6:0]});
    endtask : load
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h04, 32'h0);
        check("status reset", q, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        check("config reset", q, 32'h30F02);
        wb(1'b0, 8'h0C, 32'h0);
        check("unmapped", q, 32'h0);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b0, 8'h00, 32'h0);
        check("wake bit", q, 32'h1);
        repeat (60) @(posedge clk_i); // Standby settle before any pin
        wb(1'b0, 8'h04, 32'h0);
        check("idle after wake", q, 32'h4);
        host_u.direct(2, 32'h2, 100);
        check("no air unconfigured", {16'h0, on_cnt}, 32'h0);
        cfg = 20'h30F02;
        for (int p = 0; p < 4; p++) begin
            w = {23'h0, p[1:0], 7'($random(seed))};
            load(9);
            check("power", {24'h0, power_dbm_o}, {24'h0, dbm(p[1:0])});
        end
        // Single-bit corner: only the lowest channel bit moves
        w = $random(seed);
        load(1);
        wb(1'b0, 8'h04, 32'h0);
        check("configured idle", q, 32'h204);
        w = {12'h0, 6'h0C, 1'b1, 1'b1, 3'h3, 2'h3, 7'h28};
        load(20);
        check("fast rate", {31'h0, fast_rate_o}, 32'h1);
        n = 4 + ($random(seed) & 15);
        w = $random(seed);
        host_u.frame(1'b0, n, w, 100);
        wait_air(1'b1);
        repeat (50) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            check("burst bit", {31'h0, tx_data_o}, {31'h0, w[i]});
            repeat (100) @(posedge clk_i);
        end
        wait_air(1'b0);
        check("burst airtime", {16'h0, on_cnt}, (n + 1) * 100);
        code = $random(seed) & 7;
        w = {18'h0, 2'h0, code[2:0], 2'h3, 7'($random(seed))};
        load(14);
        w = $random(seed);
        host_u.direct(16, w, 400);
        check("direct delay", {31'h0, dly_on >= DIR + xo_cyc(code)
            && dly_on <= DIR + xo_cyc(code) + 8}, 32'h1);
        wait_air(1'b0);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'h08, 32'hFFFFF);
        wb(1'b0, 8'h08, 32'h0);
        check("config after power loss", q, 32'h30F02);
        wb(1'b0, 8'h04, 32'h0);
        check("status after power loss", q, 32'h1);
        results();
    end
endmodule : test_radio_tx_mode_sequencer
`default_nettype wire
